// file: common/nbs_regs.svh
`ifndef NBS_REGS_SVH
`define NBS_REGS_SVH
// register indexes on the plain register port
`define NBS_REG_FLAGS 4'h0
`define NBS_REG_LEVEL 4'h1
`define NBS_REG_PROT 4'h2
// boot control flag register bit positions
`define NBS_FLAG_RUN_POR 0
`define NBS_FLAG_RUN_SYS 1
`define NBS_FLAG_SKIP 2
`define NBS_FLAG_PASS 3
`define NBS_FLAG_BUSY 4
// boot protection byte bit positions
`define NBS_PROT_AUTO 0
`define NBS_PROT_RESTRICT 1
`define NBS_PROT_LOCK 2
`define NBS_PROT_RST 8'h00
// unified ram and jump target
`define NBS_RAM_DEPTH 16'h1200
`define NBS_JUMP_ADDR 16'h0000
// status variable addresses
`define NBS_VAR_PTR_HI 16'h11f3
`define NBS_VAR_PTR_LO 16'h11f4
`define NBS_VAR_UBEG_HI 16'h11f5
`define NBS_VAR_UBEG_LO 16'h11f6
`define NBS_VAR_COPY_HI 16'h11fd
`define NBS_VAR_COPY_LO 16'h11fe
`define NBS_VAR_STAT 16'h11ff
// boot result codes
`define NBS_STAT_OK0 8'h00
`define NBS_STAT_OK1 8'h80
`define NBS_FERR_LEVEL 3'h1
`define NBS_FERR_ADDR 3'h2
// last byte index of the factory header and of the status block
`define NBS_HDR_LAST 3'h6
`define NBS_STAT_LAST 3'h6
`endif

// file: common/nbs_pkg.sv
`default_nettype none
package nbs_pkg;
  // boot sequencer states
  typedef enum logic [3:0] {
    NBS_ST_IDLE = 4'h0,
    NBS_ST_START = 4'h1,
    NBS_ST_F_HDR = 4'h2,
    NBS_ST_F_REC = 4'h3,
    NBS_ST_U_HDR = 4'h4,
    NBS_ST_U_COPY = 4'h5,
    NBS_ST_STAT = 4'h6,
    NBS_ST_WAIT = 4'h7,
    NBS_ST_RUN = 4'h8
  } nbs_state_e;
  // chip program levels
  typedef enum logic [2:0] {
    NBS_LVL_FACTORY = 3'h0,
    NBS_LVL_USER = 3'h1,
    NBS_LVL_RUN = 3'h2
  } nbs_level_e;
endpackage
`default_nettype wire

// file: design/nbs_boot_sequencer.sv
// Operation
// - boot starts on power, wake, debug reset
// - factory load fills registers, ram, variables
// - factory level waits for run request
// - user level copies user load, then waits
// - skip flag omits user load on user level parts; cleared by power
// - skip flag beats auto-run bit
// - auto-run bit is write-once
// - auto-run user part jumps to zero
// - host can still halt auto-run cpu
// - run level jumps, debug port off
// - run part retest restricted or locked
// - result byte 0x00/0x80 means success
// - pass bit mirrored in flag register
// - one unified ram 0x0000 to 0x11ff
// - two-byte pointer to reserved ram start
// - status variables at 0x11f3..0x11ff
// - multi-byte variables stored msb first
// - result bit 7 holds sampled pin 0
// - factory failure in three-bit error field
// - program level readable after boot
`timescale 1ns/1ps
`default_nettype none
`include "nbs_regs.svh"
module nbs_boot_sequencer (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic por_in,
  input wire logic wake_in,
  input wire logic dbg_reset_in,
  input wire logic retest_in,
  input wire logic gpio0_in,
  output logic nvm_rd_out,
  output logic [12:0] nvm_addr_out,
  input wire logic [7:0] nvm_rdata_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [15:0] fetch_addr_in,
  output logic [7:0] fetch_data_out,
  input wire logic [15:0] xdata_addr_in,
  input wire logic [7:0] xdata_wdata_in,
  input wire logic xdata_we_in,
  output logic [7:0] xdata_rdata_out,
  output logic cpu_run_out,
  output logic cpu_jump_out,
  output logic [15:0] cpu_jump_addr_out,
  output logic debug_en_out,
  output logic debug_restricted_out,
  output logic boot_busy_out
);
  nbs_pkg::nbs_state_e st_q; // sequencer state
  logic phase_q; // high in the cycle nvm data is valid
  logic [12:0] nvm_ptr_q; // next nvm byte to read
  logic [2:0] idx_q; // byte index in header or status block
  logic [1:0] rsub_q; // byte within a factory record
  logic [15:0] cnt_q; // records or user bytes left
  logic [15:0] rec_addr_q; // ram target of a factory record
  logic [15:0] uaddr_q; // ram target of user copy
  logic [2:0] level_q; // program level field
  logic [7:0] prot_q; // boot protection byte
  logic [15:0] rsv_ptr_q; // reserved ram start pointer
  logic [15:0] ubeg_q; // nvm start of user load
  logic [2:0] ferr_q; // factory error field
  logic uerr_q; // first user block error
  logic gpio_q; // pin 0 boot sample
  logic retest_q; // retest request sampled at boot start
  logic run_por_q; // run request flags set by the host
  logic run_sys_q;
  logic skip_q; // skip user load flag
  logic pass_q; // boot pass bit
  logic dbg_q; // debug port enable
  logic jump_q; // one-cycle jump to ram zero
  logic [7:0] rdata_q;
  logic [7:0] fetch_q;
  logic [7:0] xrd_q;
  logic [7:0] ram_q [0:`NBS_RAM_DEPTH-16'h0001];
  logic boot_evt; // any boot trigger
  logic rd_state; // a state that reads nvm
  logic lvl_user;
  logic lvl_run;
  logic go_user; // user load follows the factory load
  logic auto_go; // user part runs without waiting
  logic stat_done; // last status byte written this cycle
  logic [7:0] stat_byte; // boot result byte
  logic bw_en; // ram write port
  logic [15:0] bw_addr;
  logic [7:0] bw_data;

  assign boot_evt = por_in | wake_in | dbg_reset_in;
  assign rd_state = (st_q == nbs_pkg::NBS_ST_F_HDR) || (st_q == nbs_pkg::NBS_ST_F_REC) ||
                    (st_q == nbs_pkg::NBS_ST_U_HDR) || (st_q == nbs_pkg::NBS_ST_U_COPY);
  assign lvl_user = (level_q == nbs_pkg::NBS_LVL_USER);
  assign lvl_run = (level_q == nbs_pkg::NBS_LVL_RUN);
  assign go_user = lvl_run | (lvl_user & ~skip_q);
  assign auto_go = lvl_user & prot_q[`NBS_PROT_AUTO] & ~skip_q;
  assign stat_done = (st_q == nbs_pkg::NBS_ST_STAT) && (idx_q == `NBS_STAT_LAST);
  assign stat_byte = {gpio_q, 2'b00, ferr_q, 1'b0, uerr_q};
  // reads are split in two cycles: address out, then data back
  assign nvm_rd_out = rd_state & ~phase_q;
  assign nvm_addr_out = nvm_ptr_q;
  assign cpu_run_out = (st_q == nbs_pkg::NBS_ST_RUN);
  assign cpu_jump_out = jump_q;
  assign cpu_jump_addr_out = `NBS_JUMP_ADDR;
  assign debug_en_out = dbg_q;
  assign debug_restricted_out = dbg_q & lvl_run & prot_q[`NBS_PROT_RESTRICT];
  assign boot_busy_out = ~((st_q == nbs_pkg::NBS_ST_IDLE) || (st_q == nbs_pkg::NBS_ST_WAIT) ||
                           (st_q == nbs_pkg::NBS_ST_RUN));
  assign reg_rdata_out = rdata_q;
  assign fetch_data_out = fetch_q;
  assign xdata_rdata_out = xrd_q;

  // single ram write port: boot loads first, cpu only once running
  always_comb begin
    bw_en = 1'b0;
    bw_addr = 16'h0000;
    bw_data = 8'h00;
    if ((st_q == nbs_pkg::NBS_ST_F_REC) && phase_q && (rsub_q == 2'h2)) begin
      bw_en = (rec_addr_q < `NBS_RAM_DEPTH);
      bw_addr = rec_addr_q;
      bw_data = nvm_rdata_in;
    end else if ((st_q == nbs_pkg::NBS_ST_U_COPY) && phase_q) begin
      bw_en = (uaddr_q < rsv_ptr_q);
      bw_addr = uaddr_q;
      bw_data = nvm_rdata_in;
    end else if (st_q == nbs_pkg::NBS_ST_STAT) begin
      bw_en = 1'b1;
      unique case (idx_q)
        3'h0: begin
          bw_addr = `NBS_VAR_PTR_HI;
          bw_data = rsv_ptr_q[15:8];
        end
        3'h1: begin
          bw_addr = `NBS_VAR_PTR_LO;
          bw_data = rsv_ptr_q[7:0];
        end
        3'h2: begin
          bw_addr = `NBS_VAR_UBEG_HI;
          bw_data = ubeg_q[15:8];
        end
        3'h3: begin
          bw_addr = `NBS_VAR_UBEG_LO;
          bw_data = ubeg_q[7:0];
        end
        3'h4: begin
          bw_addr = `NBS_VAR_COPY_HI;
          bw_data = {3'h0, nvm_ptr_q[12:8]};
        end
        3'h5: begin
          bw_addr = `NBS_VAR_COPY_LO;
          bw_data = nvm_ptr_q[7:0];
        end
        default: begin
          bw_addr = `NBS_VAR_STAT;
          bw_data = stat_byte;
        end
      endcase
    end else if ((st_q == nbs_pkg::NBS_ST_RUN) && xdata_we_in) begin
      bw_en = (xdata_addr_in < `NBS_RAM_DEPTH);
      bw_addr = xdata_addr_in;
      bw_data = xdata_wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (bw_en) begin
      ram_q[bw_addr[12:0]] <= bw_data;
    end
  end

  // fetch and data read ports, zero outside the ram
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      fetch_q <= 8'h00;
      xrd_q <= 8'h00;
    end else begin
      fetch_q <= (fetch_addr_in < `NBS_RAM_DEPTH) ? ram_q[fetch_addr_in[12:0]] : 8'h00;
      xrd_q <= (xdata_addr_in < `NBS_RAM_DEPTH) ? ram_q[xdata_addr_in[12:0]] : 8'h00;
    end
  end

  // sequencer; a new trigger restarts from any state
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      st_q <= nbs_pkg::NBS_ST_IDLE;
      phase_q <= 1'b0;
      nvm_ptr_q <= 13'h0000;
      idx_q <= 3'h0;
      rsub_q <= 2'h0;
      cnt_q <= 16'h0000;
      rec_addr_q <= 16'h0000;
      uaddr_q <= 16'h0000;
      level_q <= 3'h0;
      rsv_ptr_q <= 16'h0000;
      ubeg_q <= 16'h0000;
      ferr_q <= 3'h0;
      uerr_q <= 1'b0;
      gpio_q <= 1'b0;
      retest_q <= 1'b0;
      dbg_q <= 1'b0;
      jump_q <= 1'b0;
    end else if (boot_evt) begin
      st_q <= nbs_pkg::NBS_ST_START;
      dbg_q <= 1'b0;
      jump_q <= 1'b0;
    end else begin
      jump_q <= 1'b0;
      if (rd_state) begin
        phase_q <= ~phase_q;
      end
      if (rd_state && phase_q) begin
        nvm_ptr_q <= nvm_ptr_q + 13'h0001;
      end
      unique case (st_q)
        nbs_pkg::NBS_ST_IDLE: begin
        end
        nbs_pkg::NBS_ST_START: begin
          gpio_q <= gpio0_in;
          retest_q <= retest_in;
          nvm_ptr_q <= 13'h0000;
          idx_q <= 3'h0;
          phase_q <= 1'b0;
          ferr_q <= 3'h0;
          uerr_q <= 1'b0;
          st_q <= nbs_pkg::NBS_ST_F_HDR;
        end
        nbs_pkg::NBS_ST_F_HDR: begin
          if (phase_q) begin
            idx_q <= idx_q + 3'h1;
            unique case (idx_q)
              3'h0: begin
                level_q <= nvm_rdata_in[2:0];
                if (nvm_rdata_in > 8'h02) begin
                  ferr_q <= `NBS_FERR_LEVEL;
                end
              end
              3'h1: begin
              end
              3'h2: rsv_ptr_q[15:8] <= nvm_rdata_in;
              3'h3: rsv_ptr_q[7:0] <= nvm_rdata_in;
              3'h4: ubeg_q[15:8] <= nvm_rdata_in;
              3'h5: ubeg_q[7:0] <= nvm_rdata_in;
              default: begin
                cnt_q <= {8'h00, nvm_rdata_in};
                rsub_q <= 2'h0;
                idx_q <= 3'h0;
                if (nvm_rdata_in != 8'h00) begin
                  st_q <= nbs_pkg::NBS_ST_F_REC;
                end else if (go_user) begin
                  nvm_ptr_q <= ubeg_q[12:0];
                  st_q <= nbs_pkg::NBS_ST_U_HDR;
                end else begin
                  st_q <= nbs_pkg::NBS_ST_STAT;
                end
              end
            endcase
          end
        end
        nbs_pkg::NBS_ST_F_REC: begin
          if (phase_q) begin
            rsub_q <= (rsub_q == 2'h2) ? 2'h0 : rsub_q + 2'h1;
            if (rsub_q == 2'h0) begin
              rec_addr_q[15:8] <= nvm_rdata_in;
            end else if (rsub_q == 2'h1) begin
              rec_addr_q[7:0] <= nvm_rdata_in;
            end else begin
              if (rec_addr_q >= `NBS_RAM_DEPTH) begin
                ferr_q <= `NBS_FERR_ADDR;
              end
              cnt_q <= cnt_q - 16'h0001;
              if (cnt_q == 16'h0001) begin
                if (go_user) begin
                  nvm_ptr_q <= ubeg_q[12:0];
                  st_q <= nbs_pkg::NBS_ST_U_HDR;
                end else begin
                  st_q <= nbs_pkg::NBS_ST_STAT;
                end
              end
            end
          end
        end
        nbs_pkg::NBS_ST_U_HDR: begin
          if (phase_q) begin
            idx_q <= 3'h1;
            uaddr_q <= 16'h0000;
            if (idx_q == 3'h0) begin
              cnt_q[15:8] <= nvm_rdata_in;
            end else begin
              cnt_q[7:0] <= nvm_rdata_in;
              idx_q <= 3'h0;
              st_q <= ({cnt_q[15:8], nvm_rdata_in} == 16'h0000) ? nbs_pkg::NBS_ST_STAT :
                      nbs_pkg::NBS_ST_U_COPY;
            end
          end
        end
        nbs_pkg::NBS_ST_U_COPY: begin
          if (phase_q) begin
            if (uaddr_q >= rsv_ptr_q) begin
              uerr_q <= 1'b1;
            end
            uaddr_q <= uaddr_q + 16'h0001;
            cnt_q <= cnt_q - 16'h0001;
            if (cnt_q == 16'h0001) begin
              st_q <= nbs_pkg::NBS_ST_STAT;
            end
          end
        end
        nbs_pkg::NBS_ST_STAT: begin
          idx_q <= idx_q + 3'h1;
          if (stat_done) begin
            if (lvl_run) begin
              st_q <= nbs_pkg::NBS_ST_RUN;
              jump_q <= 1'b1;
              dbg_q <= retest_q & ~prot_q[`NBS_PROT_LOCK];
            end else if (auto_go) begin
              st_q <= nbs_pkg::NBS_ST_RUN;
              jump_q <= 1'b1;
              dbg_q <= 1'b1;
            end else begin
              st_q <= nbs_pkg::NBS_ST_WAIT;
              dbg_q <= 1'b1;
            end
          end
        end
        nbs_pkg::NBS_ST_WAIT: begin
          if (run_por_q || run_sys_q) begin
            st_q <= nbs_pkg::NBS_ST_RUN;
            jump_q <= 1'b1;
          end
        end
        nbs_pkg::NBS_ST_RUN: begin
        end
        default: st_q <= nbs_pkg::NBS_ST_IDLE;
      endcase
    end
  end

  // boot control flags; a power cycle clears the skip flag
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      run_por_q <= 1'b0;
      run_sys_q <= 1'b0;
      skip_q <= 1'b0;
      pass_q <= 1'b0;
    end else begin
      if (reg_wr_in && (reg_addr_in == `NBS_REG_FLAGS)) begin
        run_por_q <= reg_wdata_in[`NBS_FLAG_RUN_POR];
        run_sys_q <= reg_wdata_in[`NBS_FLAG_RUN_SYS];
        skip_q <= reg_wdata_in[`NBS_FLAG_SKIP];
      end
      if (boot_evt) begin
        run_por_q <= 1'b0;
        run_sys_q <= 1'b0;
        pass_q <= 1'b0;
      end
      if (por_in) begin
        skip_q <= 1'b0;
      end
      if (stat_done && !boot_evt) begin
        pass_q <= (stat_byte == `NBS_STAT_OK0) || (stat_byte == `NBS_STAT_OK1);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      prot_q <= `NBS_PROT_RST;
    end else begin
      // both sources only add bits; a host write in the nvm byte cycle is kept as well
      prot_q <= prot_q |
                (((st_q == nbs_pkg::NBS_ST_F_HDR) && phase_q && (idx_q == 3'h1) && !boot_evt) ?
                 nvm_rdata_in : 8'h00) |
                ((reg_wr_in && (reg_addr_in == `NBS_REG_PROT)) ? reg_wdata_in : 8'h00);
    end
  end

  // register read data, valid only in the cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      rdata_q <= 8'h00;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        `NBS_REG_FLAGS: rdata_q <= {3'h0, boot_busy_out, pass_q, skip_q, run_sys_q, run_por_q};
        `NBS_REG_LEVEL: rdata_q <= {5'h00, level_q};
        `NBS_REG_PROT: rdata_q <= prot_q;
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_final;
    stat_done && !boot_evt;
  endsequence
  sequence s_enter_user;
    st_q != nbs_pkg::NBS_ST_U_HDR ##1 st_q == nbs_pkg::NBS_ST_U_HDR;
  endsequence

  AST_START_ON_EVENT: assert property (boot_evt |=> st_q == nbs_pkg::NBS_ST_START ##1
    st_q == nbs_pkg::NBS_ST_F_HDR || $past(boot_evt)) else $error("boot did not start");
  AST_WAIT_RELEASE: assert property ($rose(cpu_run_out) && $past(st_q == nbs_pkg::NBS_ST_WAIT) |->
    $past(run_por_q || run_sys_q)) else $error("left wait loop without run request");
  AST_SKIP_NO_USER: assert property (s_enter_user |-> $past(lvl_run || !skip_q))
    else $error("user load started with skip flag");
  AST_AUTORUN: assert property ((s_final and (auto_go && !lvl_run)) |=> cpu_run_out && cpu_jump_out
    && debug_en_out) else $error("auto-run did not jump");
  AST_SKIP_WINS: assert property ((s_final and (lvl_user && skip_q)) |=>
    st_q == nbs_pkg::NBS_ST_WAIT && debug_en_out) else $error("skip flag did not win");
  AST_AUTO_ONCE: assert property (!$fell(prot_q[`NBS_PROT_AUTO]))
    else $error("auto-run bit cleared");
  AST_RUN_NODEBUG: assert property (cpu_run_out && lvl_run && !retest_q |-> !debug_en_out)
    else $error("debug port open on run part");
  AST_PASS_BIT: assert property (s_final |=> pass_q == ($past(stat_byte[6:0]) == 7'h00))
    else $error("pass bit wrong");
  AST_RAM_RANGE: assert property (bw_en |-> bw_addr < `NBS_RAM_DEPTH)
    else $error("ram write out of range");
  AST_MSB_FIRST: assert property (st_q == nbs_pkg::NBS_ST_STAT && idx_q == 3'h0 |->
    bw_addr == `NBS_VAR_PTR_HI && bw_data == rsv_ptr_q[15:8]) else $error("pointer not msb first");
  AST_NO_EARLY_RUN: assert property ($rose(cpu_run_out) |-> $past(st_q == nbs_pkg::NBS_ST_STAT
    || st_q == nbs_pkg::NBS_ST_WAIT)) else $error("cpu ran before boot end");
endmodule
`default_nettype wire

// file: verification/nbs_nvm_model.sv
`timescale 1ns/1ps
`default_nettype none
// one-time-programmable memory with a fixed one-cycle read latency
module nbs_nvm_model (
  input wire logic clk_in,
  input wire logic rd_in,
  input wire logic [12:0] addr_in,
  input wire logic [7:0] level_in,
  input wire logic [7:0] prot_in,
  output logic [7:0] rdata_out
);
  // image byte at one address; blank cells read as all ones
  function automatic logic [7:0] image(input logic [12:0] a);
    case (a)
      // factory header: level and protection byte first
      13'h0000: image = level_in;
      13'h0001: image = prot_in;
      // reserved ram start pointer, msb first
      13'h0002: image = 8'h11;
      13'h0003: image = 8'h00;
      // user load start address 0x0010
      13'h0004: image = 8'h00;
      13'h0005: image = 8'h10;
      // one factory record: ram 0x1100 gets 0xa5
      13'h0006: image = 8'h01;
      13'h0007: image = 8'h11;
      13'h0008: image = 8'h00;
      13'h0009: image = 8'ha5;
      // user load: length 2, then two code bytes
      13'h0010: image = 8'h00;
      13'h0011: image = 8'h02;
      13'h0012: image = 8'h3c;
      13'h0013: image = 8'hc3;
      default: image = 8'hff;
    endcase
  endfunction
  // data valid only in the cycle after a read; otherwise it flips so stale data never looks right
  always @(posedge clk_in) begin
    if (rd_in) begin
      rdata_out <= image(addr_in);
    end else begin
      rdata_out <= ~rdata_out;
    end
  end
  initial rdata_out = 8'h00;
endmodule
`default_nettype wire

// file: verification/tb_nbs_boot_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "nbs_regs.svh"
module tb_nbs_boot_sequencer;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic por_in = 1'b0, wake_in = 1'b0, dbg_reset_in = 1'b0, retest_in = 1'b0, gpio0_in = 1'b0;
  logic nvm_rd_out;
  logic [12:0] nvm_addr_out;
  logic [7:0] nvm_rdata_in;
  logic [3:0] reg_addr_in = 4'h0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic [15:0] fetch_addr_in = 16'h0000, xdata_addr_in = 16'h0000;
  logic [7:0] fetch_data_out, xdata_rdata_out;
  logic [7:0] xdata_wdata_in = 8'h00;
  logic xdata_we_in = 1'b0;
  logic cpu_run_out, cpu_jump_out, debug_en_out, debug_restricted_out, boot_busy_out;
  logic [15:0] cpu_jump_addr_out;
  logic [7:0] img_level = 8'h00, img_prot = 8'h00; // image contents chosen per scenario
  int n_mismatch = 0;
  int num_checks = 0;
  int jumps = 0; // jump pulses seen
  logic [7:0] v;
  int j0;

  nbs_boot_sequencer i_nbs_boot_sequencer (.clk_in(clk_in), .rstn_in(rstn_in), .por_in(por_in),
    .wake_in(wake_in), .dbg_reset_in(dbg_reset_in), .retest_in(retest_in), .gpio0_in(gpio0_in),
    .nvm_rd_out(nvm_rd_out), .nvm_addr_out(nvm_addr_out), .nvm_rdata_in(nvm_rdata_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .fetch_addr_in(fetch_addr_in),
    .fetch_data_out(fetch_data_out), .xdata_addr_in(xdata_addr_in), .xdata_wdata_in(xdata_wdata_in),
    .xdata_we_in(xdata_we_in), .xdata_rdata_out(xdata_rdata_out), .cpu_run_out(cpu_run_out),
    .cpu_jump_out(cpu_jump_out), .cpu_jump_addr_out(cpu_jump_addr_out), .debug_en_out(debug_en_out),
    .debug_restricted_out(debug_restricted_out), .boot_busy_out(boot_busy_out));
  nbs_nvm_model i_nbs_nvm_model (.clk_in(clk_in), .rd_in(nvm_rd_out), .addr_in(nvm_addr_out),
    .level_in(img_level), .prot_in(img_prot), .rdata_out(nvm_rdata_in));

  // 50 MHz clock
  initial begin
    forever #10 clk_in = ~clk_in;
  end
  // count jump pulses so a missing or doubled pulse shows up
  always @(posedge clk_in) begin
    if (cpu_jump_out === 1'b1) jumps++;
  end
  // verdict in one place only
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // register port: one-cycle strobes, read data in the following cycle only
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask
  // code-side fetch, data registered one cycle after the address
  task automatic fetch(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_in);
    fetch_addr_in <= a;
    @(posedge clk_in);
    #1 d = fetch_data_out;
  endtask
  // pulse one trigger (0 power, 1 wake, 2 debug reset) and wait out the sequence
  task automatic boot(input int which);
    int n;
    @(posedge clk_in);
    por_in <= (which == 0);
    wake_in <= (which == 1);
    dbg_reset_in <= (which == 2);
    @(posedge clk_in);
    {por_in, wake_in, dbg_reset_in} <= 3'b000;
    n = 0;
    while (boot_busy_out !== 1'b1 && n < 10) begin
      @(posedge clk_in);
      n++;
    end
    n = 0;
    while (boot_busy_out !== 1'b0 && n < 500) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 500) chk(16'h0001, 16'h0000);
    repeat (3) @(posedge clk_in);
    #1;
  endtask
  // status block at the top of ram, msb first
  task automatic stat(input logic [15:0] copy, input logic [7:0] res);
    logic [15:0] ad[7] = '{16'h11f3, 16'h11f4, 16'h11f5, 16'h11f6, 16'h11fd, 16'h11fe, 16'h11ff};
    logic [7:0] ex[7];
    ex = '{8'h11, 8'h00, 8'h00, 8'h10, copy[15:8], copy[7:0], res};
    for (int i = 0; i < 7; i++) begin
      fetch(ad[i], v);
      chk({8'h00, v}, {8'h00, ex[i]});
    end
  endtask

  // watchdog well beyond the few hundred cycles the run needs
  initial begin
    repeat (30000) @(posedge clk_in);
    n_mismatch++;
    close_out();
  end

  initial begin
    repeat (3) @(posedge clk_in);
    rstn_in <= 1'b1;
    // idle after reset: registers clear, nothing runs
    rd(`NBS_REG_FLAGS, v); chk(v, 8'h00);
    rd(`NBS_REG_PROT, v); chk(v, 8'h00);
    rd(4'hf, v); chk(v, 8'h00);
    chk(cpu_run_out, 1'b0);
    // factory part: loads, posts status, waits for a run request
    gpio0_in <= 1'b1;
    boot(0);
    stat(16'h000a, 8'h80);
    fetch(16'h1100, v); chk(v, 8'ha5);
    rd(`NBS_REG_FLAGS, v); chk(v, 8'h08);
    rd(`NBS_REG_LEVEL, v); chk(v, 8'h00);
    repeat (20) @(posedge clk_in);
    #1 chk({cpu_run_out, debug_en_out}, 2'b01);
    j0 = jumps;
    wr(`NBS_REG_FLAGS, 8'h02);
    repeat (3) @(posedge clk_in);
    #1 chk(cpu_run_out, 1'b1);
    chk(jumps - j0, 1);
    chk(cpu_jump_addr_out, 16'h0000);
    // user part: user load copied, then waits
    gpio0_in <= 1'b0;
    img_level <= 8'h01;
    boot(2);
    stat(16'h0014, 8'h00);
    fetch(16'h0000, v); chk(v, 8'h3c);
    @(posedge clk_in);
    xdata_addr_in <= 16'h0001;
    @(posedge clk_in);
    #1 chk(xdata_rdata_out, 8'hc3);
    chk({cpu_run_out, debug_en_out}, 2'b01);
    rd(`NBS_REG_LEVEL, v); chk(v, 8'h01);
    // skip flag set with auto-run in the image: skip wins, no user load
    img_prot <= 8'h01;
    wr(`NBS_REG_FLAGS, 8'h04);
    boot(1);
    stat(16'h000a, 8'h00);
    chk({cpu_run_out, debug_en_out}, 2'b01);
    rd(`NBS_REG_PROT, v); chk(v, 8'h01);
    // power cycle clears skip: auto-run part jumps with debug on
    j0 = jumps;
    boot(0);
    rd(`NBS_REG_FLAGS, v); chk(v, 8'h08);
    stat(16'h0014, 8'h00);
    chk({cpu_run_out, debug_en_out}, 2'b11);
    chk(jumps - j0, 1);
    // cpu writes land in ram once running; beyond the top reads zero
    @(posedge clk_in);
    xdata_addr_in <= 16'h0200;
    xdata_wdata_in <= 8'h5a;
    xdata_we_in <= 1'b1;
    @(posedge clk_in);
    xdata_we_in <= 1'b0;
    fetch(16'h0200, v); chk(v, 8'h5a);
    fetch(16'h1200, v); chk(v, 8'h00);
    // auto-run bit cannot be cleared by a write
    wr(`NBS_REG_PROT, 8'h00);
    rd(`NBS_REG_PROT, v); chk(v, 8'h01);
    // run part: jumps with debug port off, level read-only
    img_prot <= 8'h00;
    img_level <= 8'h02;
    boot(0);
    chk({cpu_run_out, debug_en_out, debug_restricted_out}, 3'b100);
    wr(`NBS_REG_LEVEL, 8'h00);
    rd(`NBS_REG_LEVEL, v); chk(v, 8'h02);
    // retest on a run part: debug opens restricted, then the lock bit shuts it
    retest_in <= 1'b1;
    wr(`NBS_REG_PROT, 8'h02);
    boot(0);
    chk({cpu_run_out, debug_en_out, debug_restricted_out}, 3'b111);
    wr(`NBS_REG_PROT, 8'h04);
    boot(0);
    chk({cpu_run_out, debug_en_out, debug_restricted_out}, 3'b100);
    retest_in <= 1'b0;
    // bad level byte: factory error reported, no pass
    img_level <= 8'h03;
    boot(0);
    stat(16'h000a, 8'h04);
    rd(`NBS_REG_FLAGS, v); chk(v, 8'h00);
    chk(cpu_run_out, 1'b0);
    close_out();
  end
endmodule
`default_nettype wire
